/* File: logic/oes_sampler.v */
// Behaviour
// - Control upper field shows live 27-bit interval count, software read/write.
// - Limit is 7 high bits at 26:20 and 16 low bits at 15:0.
// - Count source select zero counts clock cycles, one counts dispatched ops.
// - Counter bits 26:4 equal limit, so next op gets tagged.
// - Tagged op retiring sets sample valid; counter stops while it is set.
// - A retire setting sample valid raises an interrupt request toward interrupt controller; a software write setting it does not.
// - Enable bit set turns sampling on; clear turns it off.
// - Capture canonical 64-bit linear address of the tagged instruction.
// - Bit 38 of first data register flags invalid instruction address.
// - Bits 37..34 flag branch retired, mispredicted, taken, subroutine return.
// - Data-cache results describe only the access below a 128-bit boundary.
// - Record 16-bit cycles from cache miss detect to data delivery.
// - Bit 18 physical address valid, bit 17 linear address valid.
// - Bit 15 locked, bit 14 uncacheable, bit 13 write-combining access.
// - Bit 8 misalignment penalty, bit 7 line absent from cache.
// - Translation result: bit 5 1-Gbyte hit, bit 4 2-Mbyte hit, bit 2 miss.
// - Bit 1 flags a store, bit 0 flags a load.
// - Capture canonical 64-bit linear address of the memory operand.
// - Registers reachable only through model-specific register read and write.
// - Counter advances only while enabled and sample valid is clear.
// - Aborted tagged op: no sample, clear bits 26:7, randomize 6:0, continue.
`timescale 1ns/1ns
`default_nettype none
`include "oes_defines.vh"

module oes_sampler (
  input  wire                 i_mclk,
  input  wire                 i_rst,
  input  wire                 i_msr_wr,
  input  wire                 i_msr_rd,
  input  wire [`OES_SEL_W-1:0] i_msr_sel,
  input  wire [63:0]          i_msr_wdata,
  input  wire                 i_op_dispatch,
  input  wire                 i_tag_retire,
  input  wire                 i_tag_abort,
  input  wire [63:0]          i_ret_rip,
  input  wire                 i_ret_rip_invalid,
  input  wire                 i_ret_branch,
  input  wire                 i_ret_mispredict,
  input  wire                 i_ret_taken,
  input  wire                 i_ret_return,
  input  wire                 i_dc_result,
  input  wire                 i_dc_upper_half,
  input  wire                 i_dc_phys_valid,
  input  wire                 i_dc_lin_valid,
  input  wire                 i_dc_locked,
  input  wire                 i_dc_uncacheable,
  input  wire                 i_dc_write_comb,
  input  wire                 i_dc_misalign,
  input  wire                 i_dc_line_absent,
  input  wire                 i_dc_hit_1g,
  input  wire                 i_dc_hit_2m,
  input  wire                 i_dc_xlat_miss,
  input  wire                 i_dc_store,
  input  wire                 i_dc_load,
  input  wire [63:0]          i_dc_lin_addr,
  input  wire                 i_dc_miss_start,
  input  wire                 i_dc_data_back,
  output reg  [63:0]          o_msr_rdata,
  output reg                  o_msr_rd_valid,
  output reg                  o_tag_arm,
  output reg                  o_sample_irq
);

  localparam [2:0] ST_OFF   = 3'b001;
  localparam [2:0] ST_COUNT = 3'b010;
  localparam [2:0] ST_ARMED = 3'b100;

  function [63:0] canon;
    input [63:0] a;
    begin
      canon = {{16{a[47]}}, a[47:0]};
    end
  endfunction

  function [15:0] sat_inc;
    input [15:0] v;
    begin
      sat_inc = (v == `OES_LAT_MAX) ? v : v + 16'h0001;
    end
  endfunction

  reg [26:0]  cnt;
  reg [6:0]   max_hi;
  reg [15:0]  max_lo;
  reg         cnt_sel;
  reg         valid;
  reg         enable;
  reg [63:0]  rip;
  reg [63:0]  data1;
  reg [63:0]  data3;
  reg [63:0]  lin;
  reg [2:0]   state;
  reg [2:0]   next_state;
  reg [6:0]   lfsr;
  reg         pend_seen;
  reg [18:0]  pend_flags;
  reg [63:0]  pend_lin;
  reg         lat_run;
  reg [15:0]  lat_cnt;
  reg [26:0]  next_cnt;

  wire wr_ctl = i_msr_wr && (i_msr_sel == `OES_SEL_CTL);
  wire wr_rip = i_msr_wr && (i_msr_sel == `OES_SEL_RIP);
  wire wr_d1  = i_msr_wr && (i_msr_sel == `OES_SEL_D1);
  wire wr_d3  = i_msr_wr && (i_msr_sel == `OES_SEL_D3);
  wire wr_lin = i_msr_wr && (i_msr_sel == `OES_SEL_LIN);

  // Disable takes effect on the writing edge so a stale tag cannot linger
  wire en_next   = wr_ctl ? i_msr_wdata[`OES_ENABLE] : enable;
  wire hit       = (cnt[26:4] == {max_hi, max_lo});
  wire armed     = (state == ST_ARMED);
  wire take_ret  = armed && enable && i_tag_retire;
  wire take_abt  = armed && enable && i_tag_abort && !i_tag_retire;
  wire adv       = enable && !valid && (state == ST_COUNT) && !hit &&
                   (cnt_sel ? i_op_dispatch : 1'b1);
  wire dc_take   = armed && i_dc_result && !i_dc_upper_half && !pend_seen;
  wire miss_take = armed && i_dc_miss_start && !i_dc_upper_half;

  wire [18:0] dc_flags;
  assign dc_flags[`OES_PHYS_VAL]  = i_dc_phys_valid;
  assign dc_flags[`OES_LIN_VAL]   = i_dc_lin_valid;
  assign dc_flags[16]             = 1'b0;
  assign dc_flags[`OES_LOCKED]    = i_dc_locked;
  assign dc_flags[`OES_UNCACHE]   = i_dc_uncacheable;
  assign dc_flags[`OES_WCOMB]     = i_dc_write_comb;
  assign dc_flags[12:9]           = 4'h0;
  assign dc_flags[`OES_MISALIGN]  = i_dc_misalign;
  assign dc_flags[`OES_LINE_ABS]  = i_dc_line_absent;
  assign dc_flags[6]              = 1'b0;
  assign dc_flags[`OES_HIT_1G]    = i_dc_hit_1g;
  assign dc_flags[`OES_HIT_2M]    = i_dc_hit_2m;
  assign dc_flags[3]              = 1'b0;
  assign dc_flags[`OES_XLAT_MISS] = i_dc_xlat_miss;
  assign dc_flags[`OES_STORE]     = i_dc_store;
  assign dc_flags[`OES_LOAD]      = i_dc_load;

  always @* begin
    next_state = state;
    case (state)
      ST_OFF: begin
        if (enable) begin
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!en_next) begin
          next_state = ST_OFF;
        end else if (!valid && hit) begin
          next_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (!en_next) begin
          next_state = ST_OFF;
        end else if (i_tag_retire || i_tag_abort) begin
          next_state = ST_COUNT;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  // Software load takes priority over hardware counting in the same cycle
  always @* begin
    next_cnt = cnt;
    if (wr_ctl) begin
      next_cnt = i_msr_wdata[`OES_CUR_HI:`OES_CUR_LO];
    end else if (take_abt) begin
      next_cnt = {20'h00000, lfsr};
    end else if (adv) begin
      next_cnt = cnt + 27'h0000001;
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      state   <= ST_OFF;
      cnt     <= `OES_CNT_RST;
      max_hi  <= 7'h00;
      max_lo  <= 16'h0000;
      cnt_sel <= 1'b0;
      valid   <= 1'b0;
      enable  <= 1'b0;
      lfsr    <= `OES_LFSR_SEED;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      // Free-running so the abort reload is not correlated with the abort moment
      lfsr  <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
      if (wr_ctl) begin
        max_hi  <= i_msr_wdata[`OES_MAXH_HI:`OES_MAXH_LO];
        max_lo  <= i_msr_wdata[`OES_MAXL_HI:0];
        cnt_sel <= i_msr_wdata[`OES_CNT_SEL];
        enable  <= i_msr_wdata[`OES_ENABLE];
      end
      // A retire landing on a clearing write keeps the flag set
      if (take_ret) begin
        valid <= 1'b1;
      end else if (wr_ctl) begin
        valid <= i_msr_wdata[`OES_VALID];
      end
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      pend_seen  <= 1'b0;
      pend_flags <= 19'h00000;
      pend_lin   <= `OES_REG_RST;
      lat_run    <= 1'b0;
      lat_cnt    <= 16'h0000;
    end else if (state == ST_COUNT && next_state == ST_ARMED) begin
      pend_seen  <= 1'b0;
      pend_flags <= 19'h00000;
      pend_lin   <= `OES_REG_RST;
      lat_run    <= 1'b0;
      lat_cnt    <= 16'h0000;
    end else begin
      if (dc_take) begin
        pend_seen  <= 1'b1;
        pend_flags <= dc_flags;
        pend_lin   <= i_dc_lin_addr;
      end
      if (miss_take) begin
        lat_run <= 1'b1;
        lat_cnt <= 16'h0000;
      end else if (lat_run) begin
        lat_cnt <= sat_inc(lat_cnt);
        if (i_dc_data_back) begin
          lat_run <= 1'b0;
        end
      end
    end
  end

  // Capture beats a software write to the same register in the same cycle
  always @(posedge i_mclk) begin
    if (i_rst) begin
      rip   <= `OES_REG_RST;
      data1 <= `OES_REG_RST;
      data3 <= `OES_REG_RST;
      lin   <= `OES_REG_RST;
    end else if (take_ret) begin
      rip <= canon(i_ret_rip);
      data1                <= `OES_REG_RST;
      data1[`OES_RIP_INV]   <= i_ret_rip_invalid;
      data1[`OES_BR_RET]    <= i_ret_branch;
      data1[`OES_BR_MISP]   <= i_ret_branch && i_ret_mispredict;
      data1[`OES_BR_TAKEN]  <= i_ret_branch && i_ret_taken;
      data1[`OES_BR_RETURN] <= i_ret_branch && i_ret_return;
      data3 <= {16'h0000, lat_cnt, 13'h0000, pend_flags};
      lin   <= canon(pend_lin);
    end else begin
      if (wr_rip) begin
        rip <= i_msr_wdata;
      end
      if (wr_d1) begin
        data1 <= i_msr_wdata & `OES_D1_MASK;
      end
      if (wr_d3) begin
        data3 <= i_msr_wdata & `OES_D3_MASK;
      end
      if (wr_lin) begin
        lin <= i_msr_wdata;
      end
    end
  end

  always @(posedge i_mclk) begin
    if (i_rst) begin
      o_msr_rdata    <= `OES_REG_RST;
      o_msr_rd_valid <= 1'b0;
      o_tag_arm      <= 1'b0;
      o_sample_irq   <= 1'b0;
    end else begin
      o_msr_rd_valid <= i_msr_rd;
      o_tag_arm      <= (next_state == ST_ARMED);
      o_sample_irq   <= take_ret;
      if (i_msr_rd) begin
        case (i_msr_sel)
          `OES_SEL_CTL: begin
            o_msr_rdata <= {5'h00, cnt, 5'h00, max_hi, cnt_sel, valid, enable,
                            1'b0, max_lo};
          end
          `OES_SEL_RIP: begin
            o_msr_rdata <= rip;
          end
          `OES_SEL_D1: begin
            o_msr_rdata <= data1;
          end
          `OES_SEL_D3: begin
            o_msr_rdata <= data3;
          end
          `OES_SEL_LIN: begin
            o_msr_rdata <= lin;
          end
          default: begin
            o_msr_rdata <= `OES_REG_RST;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: logic/oes_defines.vh */
`ifndef OES_DEFINES_VH
`define OES_DEFINES_VH

// Register select codes on the model-specific register port
`define OES_SEL_W        3
`define OES_SEL_CTL      3'h0
`define OES_SEL_RIP      3'h1
`define OES_SEL_D1       3'h2
`define OES_SEL_D3       3'h3
`define OES_SEL_LIN      3'h4

// Control register fields
`define OES_CUR_HI       58
`define OES_CUR_LO       32
`define OES_MAXH_HI      26
`define OES_MAXH_LO      20
`define OES_CNT_SEL      19
`define OES_VALID        18
`define OES_ENABLE       17
`define OES_MAXL_HI      15

// First data register fields
`define OES_RIP_INV      38
`define OES_BR_RET       37
`define OES_BR_MISP      36
`define OES_BR_TAKEN     35
`define OES_BR_RETURN    34

// Third data register fields
`define OES_LAT_HI       47
`define OES_LAT_LO       32
`define OES_PHYS_VAL     18
`define OES_LIN_VAL      17
`define OES_LOCKED       15
`define OES_UNCACHE      14
`define OES_WCOMB        13
`define OES_MISALIGN     8
`define OES_LINE_ABS     7
`define OES_HIT_1G       5
`define OES_HIT_2M       4
`define OES_XLAT_MISS    2
`define OES_STORE        1
`define OES_LOAD         0

// Writable bits; everything else reads as zero
`define OES_D1_MASK      64'h0000_007C_0000_0000
`define OES_D3_MASK      64'h0000_FFFF_0006_E1B7

// Reset values and constants
`define OES_CNT_RST      27'h0000000
`define OES_REG_RST      64'h0000_0000_0000_0000
`define OES_LFSR_SEED    7'h5A
`define OES_LAT_MAX      16'hFFFF

`endif

/* File: testbench/oes_sampler_properties.sv */
`timescale 1ns/1ns
`default_nettype none
`include "oes_defines.vh"
module oes_sampler_properties (
  input wire logic                  i_mclk,
  input wire logic                  i_rst,
  input wire logic                  i_msr_rd,
  input wire logic                  i_msr_wr,
  input wire logic [`OES_SEL_W-1:0] i_msr_sel,
  input wire logic                  i_tag_retire,
  input wire logic                  i_tag_abort,
  input wire logic [63:0]           o_msr_rdata,
  input wire logic                  o_msr_rd_valid,
  input wire logic                  o_tag_arm,
  input wire logic                  o_sample_irq
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  chk_irq_one_cycle: assert property (o_sample_irq |=> !o_sample_irq)
    else $error("interrupt pulse longer than one cycle");
  chk_retire_gives_irq: assert property (o_tag_arm && i_tag_retire |=> o_sample_irq)
    else $error("retire of tagged op gave no interrupt");
  chk_irq_has_cause: assert property (o_sample_irq |-> $past(o_tag_arm && i_tag_retire))
    else $error("interrupt without a retired tagged op");
  chk_abort_no_sample: assert property (
    o_tag_arm && i_tag_abort && !i_tag_retire |=> !o_sample_irq && !o_tag_arm)
    else $error("aborted op produced a sample or kept its tag");
  chk_arm_holds: assert property (
    o_tag_arm && !i_tag_retire && !i_tag_abort && !i_msr_wr |=> o_tag_arm)
    else $error("tag dropped without cause");
  chk_read_answer: assert property (i_msr_rd |=> o_msr_rd_valid)
    else $error("read not answered after one cycle");
  chk_read_cause: assert property (o_msr_rd_valid |-> $past(i_msr_rd))
    else $error("read answer without a read");
  chk_unmapped_zero: assert property (i_msr_rd && i_msr_sel > 3'h4 |=> o_msr_rdata == 64'h0)
    else $error("unmapped select returned data");
  cov_sample: cover property (o_tag_arm ##1 o_sample_irq);
endmodule
bind oes_sampler oes_sampler_properties i_props (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_msr_rd(i_msr_rd), .i_msr_wr(i_msr_wr),
  .i_msr_sel(i_msr_sel), .i_tag_retire(i_tag_retire), .i_tag_abort(i_tag_abort),
  .o_msr_rdata(o_msr_rdata), .o_msr_rd_valid(o_msr_rd_valid), .o_tag_arm(o_tag_arm),
  .o_sample_irq(o_sample_irq));
`default_nettype wire

/* File: testbench/oes_pipe_model.sv */
`timescale 1ns/1ns
`default_nettype none
// Pipeline side: miss, data return, upper then lower cache result, then retire or abort
module oes_pipe_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_arm,
  input  wire logic       i_abort,
  input  wire logic [3:0] i_len,
  output logic            o_miss_start,
  output logic            o_data_back,
  output logic            o_dc_result,
  output logic            o_upper,
  output logic            o_retire,
  output logic            o_abort
);
  logic [4:0] step;
  logic [4:0] fin;
  always @(posedge i_mclk) begin
    if (i_rst || !i_arm) step <= 5'h00;
    else if (step != 5'h1F) step <= step + 5'h01;
  end
  assign fin          = {1'h0, i_len} + 5'h04;
  assign o_miss_start = i_arm && step == 5'h01;
  assign o_data_back  = i_arm && step == {1'h0, i_len} + 5'h01;
  // Upper part reported first so the lower one must still be taken
  assign o_upper      = i_arm && step == fin - 5'h02;
  assign o_dc_result  = i_arm && (step == fin - 5'h02 || step == fin - 5'h01);
  assign o_retire     = i_arm && step == fin && !i_abort;
  assign o_abort      = i_arm && step == fin && i_abort;
endmodule
`default_nettype wire

/* File: testbench/oes_sampler_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "oes_defines.vh"
module oes_sampler_test;
  logic i_mclk = 1'h0, i_rst = 1'h1, i_msr_wr = 1'h0, i_msr_rd = 1'h0, disp = 1'h0, ab = 1'h0;
  logic [2:0] i_msr_sel = 3'h0;
  logic [63:0] i_msr_wdata = 64'h0, rip = 64'h0, lin = 64'h0, d, ctl;
  logic [11:0] fl = 12'h000;
  logic [4:0] rf = 5'h00;
  logic [3:0] len = 4'h1, k;
  logic [6:0] mh;
  logic [15:0] ml;
  logic [26:0] tgt;
  logic src, ms, db, dcr, up, ret, abo;
  wire [63:0] rdata;
  wire rdv, arm, irq;
  wire [11:0] f = fl ^ {12{up}};
  int n_errors = 0, checked = 0, irqs = 0, exp_irqs = 0, i, n;
  oes_sampler i_oes_sampler (.i_mclk(i_mclk), .i_rst(i_rst), .i_msr_wr(i_msr_wr),
    .i_msr_rd(i_msr_rd), .i_msr_sel(i_msr_sel), .i_msr_wdata(i_msr_wdata),
    .i_op_dispatch(disp), .i_tag_retire(ret), .i_tag_abort(abo), .i_ret_rip(rip),
    .i_ret_rip_invalid(rf[4]), .i_ret_branch(rf[3]), .i_ret_mispredict(rf[2]),
    .i_ret_taken(rf[1]), .i_ret_return(rf[0]), .i_dc_result(dcr), .i_dc_upper_half(up),
    .i_dc_phys_valid(f[11]), .i_dc_lin_valid(f[10]), .i_dc_locked(f[9]),
    .i_dc_uncacheable(f[8]), .i_dc_write_comb(f[7]), .i_dc_misalign(f[6]),
    .i_dc_line_absent(f[5]), .i_dc_hit_1g(f[4]), .i_dc_hit_2m(f[3]), .i_dc_xlat_miss(f[2]),
    .i_dc_store(f[1]), .i_dc_load(f[0]), .i_dc_lin_addr(up ? ~lin : lin),
    .i_dc_miss_start(ms), .i_dc_data_back(db), .o_msr_rdata(rdata), .o_msr_rd_valid(rdv),
    .o_tag_arm(arm), .o_sample_irq(irq));
  oes_pipe_model i_oes_pipe_model (.i_mclk(i_mclk), .i_rst(i_rst), .i_arm(arm), .i_abort(ab),
    .i_len(len), .o_miss_start(ms), .o_data_back(db), .o_dc_result(dcr), .o_upper(up),
    .o_retire(ret), .o_abort(abo));
  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) begin
    disp <= 1'($urandom);
    if (irq === 1'h1) irqs++;
  end
  function [63:0] cn(input [63:0] a);
    cn = {{16{a[47]}}, a[47:0]};
  endfunction
  function [63:0] exp_rw(input [2:0] s);
    exp_rw = s == 3'h2 ? `OES_D1_MASK : s == 3'h3 ? `OES_D3_MASK : s == 3'h5 ? 64'h0 : ~64'h0;
  endfunction
  task chk(input string nm, input [63:0] e, input [63:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input [2:0] s, input [63:0] v);
    @(posedge i_mclk);
    i_msr_wr <= 1'h1;
    i_msr_sel <= s;
    i_msr_wdata <= v;
    @(posedge i_mclk);
    i_msr_wr <= 1'h0;
  endtask
  task rd(input [2:0] s);
    @(posedge i_mclk);
    i_msr_rd <= 1'h1;
    i_msr_sel <= s;
    @(posedge i_mclk);
    i_msr_rd <= 1'h0;
    @(posedge i_mclk);
    chk("read_valid", 64'h1, {63'h0, rdv});
    d = rdata;
  endtask
  task report_and_stop;
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #80000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    void'($urandom(5454));
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'h0;
    rd(3'h0);
    chk("ctl_reset", 64'h0, d);
    ctl = {5'h00, 27'h5, 5'h00, 7'h11, 1'h0, 1'h0, 1'h0, 1'h0, 16'h0000};
    wr(3'h0, ctl);
    repeat (20) @(posedge i_mclk);
    rd(3'h0);
    chk("ctl_disabled", ctl, d);
    for (n = 1; n < 6; n++) begin
      wr(n[2:0], ~64'h0);
      rd(n[2:0]);
      chk("reg_rw", exp_rw(n[2:0]), d);
    end
    for (n = 0; n < 14; n++) begin
      @(posedge i_mclk);
      mh = 7'($urandom) | 7'h40;
      ml = 16'($urandom);
      k = 4'($urandom);
      src = 1'($urandom);
      ab <= n % 4 == 3;
      len <= 4'h1 + 4'($urandom % 8);
      fl <= 12'($urandom);
      rf <= 5'($urandom);
      rip <= {$urandom, $urandom};
      lin <= {$urandom, $urandom};
      tgt = {mh, ml, 4'h0};
      wr(3'h0, {5'h00, tgt - 27'(k), 5'h00, mh, src, 1'h0, 1'h1, 1'h0, ml});
      for (i = 0; i < 400 && arm !== 1'h1; i++) @(posedge i_mclk);
      chk("tag_armed", 64'h1, {63'h0, arm});
      for (i = 0; i < 40 && arm !== 1'h0; i++) @(posedge i_mclk);
      if (!ab) begin
        exp_irqs++;
        ctl = {5'h00, tgt, 5'h00, mh, src, 1'h1, 1'h1, 1'h0, ml};
        rd(3'h0);
        chk("ctl_sampled", ctl, d);
        rd(3'h1);
        chk("instr_addr", cn(rip), d);
        rd(3'h2);
        chk("branch_data", {25'h0, rf[4], rf[3], rf[2:0] & {3{rf[3]}}, 34'h0}, d);
        rd(3'h3);
        chk("cache_data", {16'h0, 12'h0, len, 13'h0, fl[11:10], 1'h0, fl[9:7], 4'h0,
          fl[6:5], 1'h0, fl[4:3], 1'h0, fl[2:0]}, d);
        rd(3'h4);
        chk("operand_addr", cn(lin), d);
        rd(3'h0);
        chk("ctl_stopped", ctl, d);
      end else begin
        rd(3'h0);
        chk("abort_count_hi", 64'h0, {45'h0, d[58:40]});
        chk("abort_no_valid", 64'h0, {63'h0, d[18]});
      end
      wr(3'h0, {5'h00, tgt, 5'h00, mh, src, 1'h0, 1'h0, 1'h0, ml});
      chk("irq_count", 64'(exp_irqs), 64'(irqs));
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
